// ==== rtl/async_line_flow_and_event_queue.v ====
`timescale 1ns/10ps
`default_nettype none
`include "async_line_flow_defs.vh"

module async_line_flow_and_event_queue #(
	parameter NLINES = `NUM_LINES,
	parameter QDEPTH = `EVQ_DEPTH,
	parameter MODIFIED_CARD = 1'b0
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst_b,
	// initialize and master clear
	input wire i_init,
	input wire i_master_clear,
	// host register port
	input wire [2:0] i_reg_sel,
	input wire i_reg_wr,
	input wire i_reg_rd,
	input wire [15:0] i_reg_wdata,
	output wire [15:0] o_reg_rdata,
	output wire o_reg_rd_valid,
	output wire o_irq,
	// event source
	input wire i_evt_valid,
	input wire [`EVT_W-1:0] i_evt_data,
	output wire o_evt_ready,
	// per-line receive side
	input wire [NLINES-1:0] i_rx_enable,
	input wire [NLINES-1:0] i_rx_lagging,
	output wire [NLINES-1:0] o_receive_overload,
	// per-line transmit side
	input wire [NLINES-1:0] i_remote_stop,
	input wire [NLINES-1:0] i_line_at_38400,
	output wire [NLINES-1:0] o_tx_halt,
	// per-line serial data
	input wire [NLINES-1:0] i_tx_serial,
	input wire [NLINES-1:0] i_ext_rxd,
	output wire [NLINES-1:0] o_rx_serial,
	output wire [NLINES-1:0] o_ext_txd,
	output wire [NLINES-1:0] o_loopback
);

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function sel_is;
		input [2:0] sel;
		input [2:0] code;
		begin
			sel_is = (sel == code);
		end
	endfunction

	function line_hit;
		input [3:0] line_num;
		input integer idx;
		begin
			line_hit = (line_num == idx[3:0]);
		end
	endfunction

	wire clear_all = i_init | i_master_clear;
	wire wr_lcw = i_reg_wr & sel_is(i_reg_sel, `HSEL_LINE_CONTROL);
	wire wr_sel = i_reg_wr & sel_is(i_reg_sel, `HSEL_SECONDARY_SELECTOR);
	wire wr_saw = i_reg_wr & sel_is(i_reg_sel, `HSEL_SECONDARY_ACCESS);
	wire rd_new = i_reg_rd & sel_is(i_reg_sel, `HSEL_NEXT_EVENT);

	// ------------------------------------------------------------
	// secondary selector and secondary ram
	// ------------------------------------------------------------
	reg [15:0] selector_q;
	wire [15:0] sram_rdata;
	wire [`SRAM_AW-1:0] sram_addr;

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			selector_q <= `SSEL_RESET;
		end else if (wr_sel) begin
			selector_q <= i_reg_wdata;
		end
	end

	// register code high nibble, line number low nibble
	assign sram_addr = {selector_q[`SSEL_REG_HI:`SSEL_REG_LO],
		selector_q[`SSEL_LINE_HI:`SSEL_LINE_LO]};

	dual_port_ram #(
		.AW(`SRAM_AW),
		.DW(16)
	) u_secondary_ram (
		.i_clk_sys(i_clk_sys),
		.i_we(wr_saw),
		.i_waddr(sram_addr),
		.i_wdata(i_reg_wdata),
		.i_raddr(sram_addr),
		.o_rdata(sram_rdata)
	);

	// ------------------------------------------------------------
	// per-line loopback, overload and remote stop
	// ------------------------------------------------------------
	wire lcw_loop_strobe = wr_lcw & i_reg_wdata[`LCW_STROBE_BIT] &
		(i_reg_wdata[`LCW_SELECT_HI:`LCW_SELECT_LO] == `LCW_SELECT_LOOPBACK);
	wire [3:0] sel_line = selector_q[`SSEL_LINE_HI:`SSEL_LINE_LO];

	genvar g;
	generate
		for (g = 0; g < NLINES; g = g + 1) begin : g_line
			reg loop_q;
			reg overload_q;
			reg halt_q;
			reg rxs_q;
			reg txd_q;

			always @(posedge i_clk_sys or negedge i_rst_b) begin
				if (!i_rst_b) begin
					loop_q <= 1'b0;
				end else if (clear_all) begin
					loop_q <= 1'b0;
				end else if (lcw_loop_strobe && line_hit(sel_line, g)) begin
					loop_q <= i_reg_wdata[`LCW_LOOPBACK_BIT];
				end
			end

			always @(posedge i_clk_sys or negedge i_rst_b) begin
				if (!i_rst_b) begin
					overload_q <= 1'b0;
					halt_q <= 1'b0;
					rxs_q <= 1'b1;
					txd_q <= 1'b1;
				end else begin
					// one cycle latency, far inside 10/16 bit
					overload_q <= i_rx_lagging[g] & i_rx_enable[g] & ~clear_all;
					halt_q <= i_remote_stop[g] & ~loop_q &
						(i_line_at_38400[g] | MODIFIED_CARD);
					rxs_q <= loop_q ? i_tx_serial[g] : i_ext_rxd[g];
					// external lead idles at mark during loopback
					txd_q <= loop_q ? 1'b1 : i_tx_serial[g];
				end
			end

			assign o_loopback[g] = loop_q;
			assign o_receive_overload[g] = overload_q;
			assign o_tx_halt[g] = halt_q;
			assign o_rx_serial[g] = rxs_q;
			assign o_ext_txd[g] = txd_q;
		end
	endgenerate

	// ------------------------------------------------------------
	// two-entry input buffer
	// ------------------------------------------------------------
	reg [`EVT_W-1:0] buf0_q;
	reg [`EVT_W-1:0] buf1_q;
	reg [1:0] buf_cnt_q;
	wire fifo_full;
	wire buf_pop = (buf_cnt_q != 2'h0) & ~fifo_full;
	wire buf_push = i_evt_valid & o_evt_ready;

	assign o_evt_ready = (buf_cnt_q != 2'h2);

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			buf0_q <= {`EVT_W{1'b0}};
			buf1_q <= {`EVT_W{1'b0}};
			buf_cnt_q <= 2'h0;
		end else begin
			case ({buf_push, buf_pop})
				2'b10: begin
					if (buf_cnt_q == 2'h0) begin
						buf0_q <= i_evt_data;
					end else begin
						buf1_q <= i_evt_data;
					end
					buf_cnt_q <= buf_cnt_q + 2'h1;
				end
				2'b01: begin
					buf0_q <= buf1_q;
					buf_cnt_q <= buf_cnt_q - 2'h1;
				end
				2'b11: begin
					if (buf_cnt_q == 2'h1) begin
						buf0_q <= i_evt_data;
					end else begin
						buf0_q <= buf1_q;
						buf1_q <= i_evt_data;
					end
				end
				default: begin
					buf_cnt_q <= buf_cnt_q;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// event queue
	// ------------------------------------------------------------
	reg [`EVQ_AW:0] wptr_q;
	reg [`EVQ_AW:0] rptr_q;
	wire [`EVQ_AW:0] qcount = wptr_q - rptr_q;
	wire fifo_empty = (qcount == {(`EVQ_AW+1){1'b0}});
	wire [`EVT_W-1:0] q_rdata;

	assign fifo_full = (qcount == QDEPTH[`EVQ_AW:0]);

	dual_port_ram #(
		.AW(`EVQ_AW),
		.DW(`EVT_W)
	) u_event_queue (
		.i_clk_sys(i_clk_sys),
		.i_we(buf_pop),
		.i_waddr(wptr_q[`EVQ_AW-1:0]),
		.i_wdata(buf0_q),
		.i_raddr(rptr_q[`EVQ_AW-1:0]),
		.o_rdata(q_rdata)
	);

	// ------------------------------------------------------------
	// presentation of the next event word
	// ------------------------------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_FETCH = 3'b010;
	localparam ST_SHOW = 3'b100;

	reg [2:0] state_q;
	reg [`EVT_W-1:0] event_q;
	reg valid_q;
	reg irq_q;

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wptr_q <= {(`EVQ_AW+1){1'b0}};
			rptr_q <= {(`EVQ_AW+1){1'b0}};
			state_q <= ST_IDLE;
			event_q <= {`EVT_W{1'b0}};
			valid_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			if (buf_pop) begin
				wptr_q <= wptr_q + {{`EVQ_AW{1'b0}}, 1'b1};
			end
			if (clear_all) begin
				// event bits kept, validity and irq dropped
				valid_q <= 1'b0;
				irq_q <= 1'b0;
				state_q <= ST_IDLE;
			end else begin
				case (state_q)
					ST_IDLE: begin
						if (!fifo_empty) begin
							state_q <= ST_FETCH;
						end
					end
					ST_FETCH: begin
						// ram output now holds the head entry
						event_q <= q_rdata;
						valid_q <= 1'b1;
						irq_q <= 1'b1;
						rptr_q <= rptr_q + {{`EVQ_AW{1'b0}}, 1'b1};
						state_q <= ST_SHOW;
					end
					ST_SHOW: begin
						if (rd_new) begin
							valid_q <= 1'b0;
							irq_q <= 1'b0;
							state_q <= ST_IDLE;
						end
					end
					default: begin
						state_q <= ST_IDLE;
					end
				endcase
			end
		end
	end

	assign o_irq = irq_q;

	// ------------------------------------------------------------
	// host read data
	// ------------------------------------------------------------
	reg rd_stage_q;
	reg [2:0] rd_sel_q;
	reg [15:0] rd_hold_q;
	reg [15:0] rdata_q;
	reg rd_valid_q;

	always @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_stage_q <= 1'b0;
			rd_sel_q <= 3'h0;
			rd_hold_q <= `NEW_RESET;
			rdata_q <= 16'h0000;
			rd_valid_q <= 1'b0;
		end else begin
			rd_stage_q <= i_reg_rd;
			rd_sel_q <= i_reg_sel;
			// capture word as seen at the read edge
			case (i_reg_sel)
				`HSEL_SYSTEM_CONTROL: begin
					rd_hold_q <= {irq_q, 15'h0000};
				end
				`HSEL_NEXT_EVENT: begin
					rd_hold_q <= {valid_q, event_q};
				end
				`HSEL_SECONDARY_SELECTOR: begin
					rd_hold_q <= selector_q;
				end
				default: begin
					rd_hold_q <= 16'h0000;
				end
			endcase
			rd_valid_q <= rd_stage_q;
			if (rd_stage_q) begin
				rdata_q <= sel_is(rd_sel_q, `HSEL_SECONDARY_ACCESS) ?
					sram_rdata : rd_hold_q;
			end
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_reg_rd_valid = rd_valid_q;

endmodule

`default_nettype wire

// ==== rtl/async_line_flow_defs.vh ====
`ifndef ASYNC_LINE_FLOW_DEFS_VH
`define ASYNC_LINE_FLOW_DEFS_VH

// host word selector codes
`define HSEL_SYSTEM_CONTROL 3'h0
`define HSEL_NEXT_EVENT 3'h1
`define HSEL_SECONDARY_SELECTOR 3'h2
`define HSEL_SECONDARY_ACCESS 3'h3
`define HSEL_LINE_CONTROL 3'h4

// line control word fields
`define LCW_STROBE_BIT 15
`define LCW_LOOPBACK_BIT 11
`define LCW_SELECT_HI 10
`define LCW_SELECT_LO 9
`define LCW_SELECT_LOOPBACK 2'h3

// secondary selector fields
`define SSEL_LINE_HI 3
`define SSEL_LINE_LO 0
`define SSEL_REG_HI 11
`define SSEL_REG_LO 8
`define SSEL_RESET 16'h0000

// next event word and system control word
`define NEW_VALID_BIT 15
`define SCW_IRQ_BIT 15
`define NEW_RESET 16'h0000

// sizes and timing
`define NUM_LINES 16
`define EVQ_DEPTH 64
`define EVQ_AW 6
`define EVT_W 15
`define SRAM_AW 8
`define CLK_PERIOD_NS 20
`define OVERLOAD_MAX_NUM 10
`define OVERLOAD_MAX_DEN 16

`endif

// ==== rtl/dual_port_ram.v ====
`timescale 1ns/10ps
`default_nettype none

module dual_port_ram #(
	parameter AW = 6,
	parameter DW = 15
) (
	// clock
	input wire i_clk_sys,
	// write port
	input wire i_we,
	input wire [AW-1:0] i_waddr,
	input wire [DW-1:0] i_wdata,
	// read port
	input wire [AW-1:0] i_raddr,
	output reg [DW-1:0] o_rdata
);

	reg [DW-1:0] mem_q [0:(1<<AW)-1];

	always @(posedge i_clk_sys) begin
		if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
		o_rdata <= mem_q[i_raddr];
	end

endmodule

`default_nettype wire

// ==== testbench/flow_checker_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module flow_checker #(
	parameter NLINES = 16
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// host side
	input wire logic i_init,
	input wire logic i_master_clear,
	input wire logic [2:0] i_reg_sel,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic o_reg_rd_valid,
	input wire logic o_irq,
	// line side
	input wire logic [NLINES-1:0] i_rx_enable,
	input wire logic [NLINES-1:0] i_rx_lagging,
	input wire logic [NLINES-1:0] i_remote_stop,
	input wire logic [NLINES-1:0] i_line_at_38400,
	input wire logic [NLINES-1:0] i_tx_serial,
	input wire logic [NLINES-1:0] i_ext_rxd,
	input wire logic [NLINES-1:0] o_receive_overload,
	input wire logic [NLINES-1:0] o_tx_halt,
	input wire logic [NLINES-1:0] o_rx_serial,
	input wire logic [NLINES-1:0] o_ext_txd,
	input wire logic [NLINES-1:0] o_loopback
);
	wire logic clr = i_init | i_master_clear;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	chk_overload_map: assert property (!clr |=>
		o_receive_overload == $past(i_rx_lagging & i_rx_enable)) else $error("overload wrong");
	chk_init_clear: assert property (clr |=>
		!o_irq && o_loopback == '0 && o_receive_overload == '0) else $error("init clear wrong");
	chk_halt_map: assert property (!clr |=>
		o_tx_halt == $past(i_remote_stop & i_line_at_38400 & ~o_loopback)) else $error("halt wrong");
	chk_rx_mux: assert property (1 |=> o_rx_serial ==
		$past((o_loopback & i_tx_serial) | (~o_loopback & i_ext_rxd))) else $error("rx mux wrong");
	chk_txd_mux: assert property (1 |=>
		o_ext_txd == $past(o_loopback | i_tx_serial)) else $error("txd mux wrong");
	chk_irq_drop: assert property (i_reg_rd && i_reg_sel == 3'h1 && o_irq |=> !o_irq)
		else $error("irq not dropped");
	chk_read_latency: assert property (i_reg_rd |-> ##2 o_reg_rd_valid)
		else $error("read answer late");
	chk_read_cause: assert property (o_reg_rd_valid |-> $past(i_reg_rd, 2))
		else $error("read answer unasked");
	chk_loop_hold: assert property (!(i_reg_wr && i_reg_sel == 3'h4) && !clr
		|=> $stable(o_loopback)) else $error("loopback changed");
endmodule
bind async_line_flow_and_event_queue flow_checker #(.NLINES(NLINES)) chk_u (
	.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_init(i_init),
	.i_master_clear(i_master_clear), .i_reg_sel(i_reg_sel), .i_reg_wr(i_reg_wr),
	.i_reg_rd(i_reg_rd), .o_reg_rd_valid(o_reg_rd_valid), .o_irq(o_irq),
	.i_rx_enable(i_rx_enable), .i_rx_lagging(i_rx_lagging), .i_remote_stop(i_remote_stop),
	.i_line_at_38400(i_line_at_38400), .i_tx_serial(i_tx_serial), .i_ext_rxd(i_ext_rxd),
	.o_receive_overload(o_receive_overload), .o_tx_halt(o_tx_halt),
	.o_rx_serial(o_rx_serial), .o_ext_txd(o_ext_txd), .o_loopback(o_loopback));
`default_nettype wire

// ==== testbench/line_partner.sv ====
`timescale 1ns/10ps
`default_nettype none
module line_partner (
	// clock and command
	input wire logic i_clk_sys,
	input wire logic i_stop_cmd,
	// device side
	input wire logic [15:0] i_overload,
	output logic [15:0] o_remote_stop,
	output logic [15:0] o_rxd
);
	assign o_remote_stop = {16{i_stop_cmd}};
	initial o_rxd = 16'h0000;
	// held-off remote transmitter idles at mark
	always @(posedge i_clk_sys) begin
		o_rxd <= #1 ~o_rxd | i_overload;
	end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk = 0, rst_b = 0, init = 0, mc = 0, wr = 0, rd = 0, ev_v = 0, stop = 0;
	logic [2:0] sel = 0;
	logic [14:0] ev_d = 0;
	logic [15:0] wd = 0, en = 0, lag = 0, spd = 0, tx = 0, got;
	logic [15:0] rdat, ovl, rstop, rxd, halt, rxs, etx, loop;
	logic rv, irq, ev_r;
	int failures = 0, n_compared = 0, i, k;
	always #10 clk = ~clk;
	async_line_flow_and_event_queue dut_u (.i_clk_sys(clk), .i_rst_b(rst_b), .i_init(init),
		.i_master_clear(mc), .i_reg_sel(sel), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rd_valid(rv), .o_irq(irq),
		.i_evt_valid(ev_v), .i_evt_data(ev_d), .o_evt_ready(ev_r), .i_rx_enable(en),
		.i_rx_lagging(lag), .o_receive_overload(ovl), .i_remote_stop(rstop),
		.i_line_at_38400(spd), .o_tx_halt(halt), .i_tx_serial(tx), .i_ext_rxd(rxd),
		.o_rx_serial(rxs), .o_ext_txd(etx), .o_loopback(loop));
	line_partner far_u (.i_clk_sys(clk), .i_stop_cmd(stop), .i_overload(ovl),
		.o_remote_stop(rstop), .o_rxd(rxd));
	task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr_w(input logic [2:0] s, input logic [15:0] d);
		@(posedge clk);
		#1 sel = s;
		wd = d;
		wr = 1;
		@(posedge clk);
		#1 wr = 0;
	endtask
	task rd_w(input logic [2:0] s);
		@(posedge clk);
		#1 sel = s;
		rd = 1;
		@(posedge clk);
		#1 rd = 0;
		k = 0;
		while (rv !== 1'b1 && k < 8) begin
			@(posedge clk);
			#1 k++;
		end
		cmp("read valid", 16'h0001, {15'h0000, rv});
		got = rdat;
	endtask
	task ev(input logic [14:0] d);
		@(posedge clk);
		#1 ev_v = 1;
		ev_d = d;
		k = 0;
		while (ev_r !== 1'b1 && k < 9) begin
			@(posedge clk);
			#1 k++;
		end
		cmp("evt ready", 16'h0001, {15'h0000, ev_r});
		@(posedge clk);
		#1 ev_v = 0;
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wrap_up;
		$display("failures %0d n_compared %0d", failures, n_compared);
		if (failures == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		$display("Error watchdog expected finish seen timeout");
		wrap_up;
	end
	initial begin
		tick(8);
		rst_b = 1;
		en = 16'h00ff;
		lag = 16'hffff;
		spd = 16'h00f0;
		tx = 16'h5555;
		stop = 1;
		tick(2);
		cmp("overload", 16'h00ff, ovl);
		cmp("halt", 16'h00f0, halt);
		mc = 1;
		tick(1);
		mc = 0;
		cmp("overload", 16'h0000, ovl);
		wr_w(3'h2, 16'h0305);
		wr_w(3'h3, 16'h1234);
		wr_w(3'h2, 16'h0a0c);
		wr_w(3'h3, 16'h5678);
		rd_w(3'h3);
		cmp("access", 16'h5678, got);
		wr_w(3'h2, 16'h0305);
		rd_w(3'h3);
		cmp("access", 16'h1234, got);
		rd_w(3'h2);
		cmp("selector", 16'h0305, got);
		wr_w(3'h4, 16'h8e00);
		wr_w(3'h2, 16'h0006);
		wr_w(3'h4, 16'h0e00);
		wr_w(3'h4, 16'h8c00);
		tick(2);
		cmp("loopback", 16'h0020, loop);
		rd_w(3'h4);
		cmp("line control", 16'h0000, got);
		cmp("halt", 16'h00d0, halt);
		cmp("ext txd", 16'h5575, etx);
		cmp("rx serial", 16'h0000, rxs & 16'h0020);
		wr_w(3'h2, 16'h0305);
		wr_w(3'h4, 16'h8600);
		tick(2);
		cmp("loopback", 16'h0000, loop);
		cmp("ext txd", 16'h5555, etx);
		rd_w(3'h3);
		cmp("access", 16'h1234, got);
		stop = 0;
		tick(2);
		cmp("halt", 16'h0000, halt);
		for (i = 0; i < 67; i++) ev(15'h0100 + i[14:0]);
		tick(4);
		cmp("evt ready", 16'h0000, {15'h0000, ev_r});
		cmp("irq", 16'h0001, {15'h0000, irq});
		for (i = 0; i < 67; i++) begin
			rd_w(3'h1);
			cmp("next event", {1'b1, 15'h0100 + i[14:0]}, got);
		end
		rd_w(3'h1);
		cmp("next event", 16'h0142, got);
		rd_w(3'h0);
		cmp("system control", 16'h0000, got);
		ev(15'h0abc);
		tick(4);
		init = 1;
		tick(1);
		init = 0;
		rd_w(3'h1);
		cmp("next event", 16'h0abc, got);
		cmp("loopback", 16'h0000, loop);
		wrap_up;
	end
endmodule
`default_nettype wire
